// ---- pkg/ush_pkg.sv ----
package ush_pkg;

  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 9;
  localparam int TIMEOUT_W = 16;
  localparam int LINE_N = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_MASK_VIEW = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_RX_HOLD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_TX_HOLD = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_INT_DISABLE = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 6'h1C;

  // Status and mask bit positions
  localparam int BIT_RX_CHAR_AVAILABLE = 0;
  localparam int BIT_TX_HOLDING_FREE = 1;
  localparam int BIT_BREAK_SEEN = 2;
  localparam int BIT_RX_DMA_END = 3;
  localparam int BIT_TX_DMA_END = 4;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_FRAMING = 6;
  localparam int BIT_PARITY = 7;
  localparam int BIT_TIMEOUT = 8;
  localparam int BIT_TX_DRAINED = 9;
  localparam int BIT_RETRY_LIMIT = 10;
  localparam int BIT_TX_DMA_EMPTY = 11;
  localparam int BIT_RX_DMA_FULL = 12;
  localparam int BIT_NOT_ACK = 13;
  localparam int BIT_LINE_CHANGE = 16;
  localparam int BIT_LINE_LEVEL = 20;

  // Bits of the mask that exist
  localparam logic [DATA_W-1:0] MASK_VALID = 32'h000F3FFF;

  // Command register bit positions
  localparam int CMD_RESET_STATUS = 0;
  localparam int CMD_RESET_NAK = 1;
  localparam int CMD_RESET_RETRY = 2;
  localparam int CMD_START_BREAK = 3;
  localparam int CMD_RX_ENABLE = 4;
  localparam int CMD_RX_DISABLE = 5;
  localparam int CMD_TX_ENABLE = 6;
  localparam int CMD_TX_DISABLE = 7;
  localparam int CMD_START_TIMEOUT = 8;

  // Reset values
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [CHAR_W-1:0] CHAR_RESET = 9'h000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ush_pkg

// ---- logic/ush_line_watch.sv ----
`timescale 1ns/1ps

// Detects level changes on the modem control lines
module ush_line_watch (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ush_pkg::LINE_N-1:0] lineLevel,
  output logic [ush_pkg::LINE_N-1:0] lineChanged
);

  typedef struct packed {
    logic primed;
    logic [ush_pkg::LINE_N-1:0] prevLevel;
  } ush_watch_s;

  ush_watch_s s_r;
  ush_watch_s s_nxt;

  // Per-line compare against the last sampled level
  genvar g;
  generate
    for (g = 0; g < ush_pkg::LINE_N; g++) begin : gLine
      assign lineChanged[g] = s_r.primed & (lineLevel[g] ^ s_r.prevLevel[g]);
    end
  endgenerate

  // First cycle after reset only learns the levels, so no false change is seen
  always_comb begin
    s_nxt = s_r;
    s_nxt.primed = 1'b1;
    s_nxt.prevLevel = lineLevel;
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ush_line_watch

// ---- logic/ush_status_regs.sv ----
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// How it works
// - Mask view reads one for each enabled source in bits 0-13 and 16-19.
// - Receive ready set by a received character, cleared by reading it or disabling.
// - Characters arriving while receiver off raise receive ready on re-enable.
// - Transmit free is low while holding full, break pending or transmitter off.
// - Break seen flag latches on break or break end until reset-status.
// - Bits 3 and 4 follow the DMA end-of-transfer signals directly.
// - Overrun flag latches on any receive overrun until reset-status.
// - Framing flag latches when a stop bit is sampled low until reset-status.
// - Parity flag latches on a parity error until reset-status.
// - Timeout flag sets on expiry after start-timeout; stays low when value zero.
// - Drained bit low while holding or shifter hold data or transmitter off.
// - Retry limit flag latches when repetitions run out until reset-retry.
// - Bits 11 and 12 follow DMA buffer empty and buffer full directly.
// - Not-acknowledged flag latches on a NOT_ACKNOWLEDGED_FLAG until the reset-NAK command.
// - Modem line change flags latch on any change, cleared by status read.
// - Bits 20 to 23 show the live modem line levels.
// - Receive holding returns the last character in bits 0 to 8.
// - Transmit holding write queues a character behind the one shifting out.
module ush_status_regs (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ush_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ush_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ush_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ush_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxCharValid,
  input wire logic [ush_pkg::CHAR_W-1:0] rxCharData,
  input wire logic rxParityErr,
  input wire logic rxFrameErr,
  input wire logic rxBreakEvt,
  input wire logic rxOverrunEvt,
  input wire logic rxTimeoutEvt,
  input wire logic nackEvt,
  input wire logic retryLimitEvt,
  output logic txCharValid,
  output logic [ush_pkg::CHAR_W-1:0] txCharData,
  input wire logic txCharTake,
  input wire logic txShifterBusy,
  output logic breakRequest,
  input wire logic breakTaken,
  input wire logic rxDmaTransferEnd,
  input wire logic txDmaTransferEnd,
  input wire logic txDmaBufferEmpty,
  input wire logic rxDmaBufferFull,
  input wire logic ringLine,
  input wire logic setReadyLine,
  input wire logic carrierLine,
  input wire logic clearSendLine,
  output logic rxEnabled,
  output logic txEnabled,
  output logic timeoutRestart,
  output logic [ush_pkg::TIMEOUT_W-1:0] timeoutValue,
  output logic irq
);

  typedef struct packed {
    logic awHeld;
    logic [ush_pkg::ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [ush_pkg::DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [ush_pkg::DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic [ush_pkg::DATA_W-1:0] intMask;
    logic rxOn;
    logic txOn;
    logic rxCharAvailable;
    logic rxPendingOff;
    logic [ush_pkg::CHAR_W-1:0] receivedCharacter;
    logic holdingFull;
    logic [ush_pkg::CHAR_W-1:0] characterToSend;
    logic breakPending;
    logic timeoutRestart;
    logic breakSeenFlag;
    logic overrunFlag;
    logic framingFlag;
    logic parityErrorFlag;
    logic timeoutFlag;
    logic retryLimitFlag;
    logic notAcknowledgedFlag;
    logic [ush_pkg::LINE_N-1:0] lineChange;
    logic [ush_pkg::TIMEOUT_W-1:0] toValue;
  } ush_state_s;

  ush_state_s s_r;
  ush_state_s s_nxt;

  logic [ush_pkg::LINE_N-1:0] lineLevel;
  logic [ush_pkg::LINE_N-1:0] lineChanged;
  logic [ush_pkg::DATA_W-1:0] statusVec;
  logic txHoldingFree;
  logic txFullyDrained;

  // Modem lines in status order: ring, set ready, carrier, clear to send
  assign lineLevel = {clearSendLine, carrierLine, setReadyLine, ringLine};

  ush_line_watch uWatch (
    .clock(clock),
    .rstn(rstn),
    .lineLevel(lineLevel),
    .lineChanged(lineChanged)
  );

  // Transmitter readiness derived from holding and break state
  // transmit free
  assign txHoldingFree = s_r.txOn & ~s_r.holdingFull & ~s_r.breakPending;
  assign txFullyDrained = s_r.txOn & ~s_r.holdingFull & ~txShifterBusy;

  // Assemble the channel status word
  always_comb begin
    statusVec = '0;
    statusVec[ush_pkg::BIT_RX_CHAR_AVAILABLE] = s_r.rxCharAvailable;
    statusVec[ush_pkg::BIT_TX_HOLDING_FREE] = txHoldingFree;
    statusVec[ush_pkg::BIT_BREAK_SEEN] = s_r.breakSeenFlag;
    statusVec[ush_pkg::BIT_RX_DMA_END] = rxDmaTransferEnd;
    statusVec[ush_pkg::BIT_TX_DMA_END] = txDmaTransferEnd;
    statusVec[ush_pkg::BIT_OVERRUN] = s_r.overrunFlag;
    statusVec[ush_pkg::BIT_FRAMING] = s_r.framingFlag;
    statusVec[ush_pkg::BIT_PARITY] = s_r.parityErrorFlag;
    statusVec[ush_pkg::BIT_TIMEOUT] = s_r.timeoutFlag;
    statusVec[ush_pkg::BIT_TX_DRAINED] = txFullyDrained;
    statusVec[ush_pkg::BIT_RETRY_LIMIT] = s_r.retryLimitFlag;
    statusVec[ush_pkg::BIT_TX_DMA_EMPTY] = txDmaBufferEmpty;
    statusVec[ush_pkg::BIT_RX_DMA_FULL] = rxDmaBufferFull;
    statusVec[ush_pkg::BIT_NOT_ACK] = s_r.notAcknowledgedFlag;
    statusVec[ush_pkg::BIT_LINE_CHANGE +: ush_pkg::LINE_N] = s_r.lineChange;
    statusVec[ush_pkg::BIT_LINE_LEVEL +: ush_pkg::LINE_N] = lineLevel;
  end

  // Bus handshakes: one write and one read outstanding at most
  assign awready = ~s_r.awHeld & ~s_r.bValid;
  assign wready = ~s_r.wHeld & ~s_r.bValid;
  assign arready = ~s_r.rValid;
  assign bvalid = s_r.bValid;
  assign bresp = s_r.bResp;
  assign rvalid = s_r.rValid;
  assign rdata = s_r.rData;
  assign rresp = s_r.rResp;

  // Engine-facing outputs
  assign txCharValid = s_r.holdingFull & s_r.txOn;
  assign txCharData = s_r.characterToSend;
  assign breakRequest = s_r.breakPending;
  assign rxEnabled = s_r.rxOn;
  assign txEnabled = s_r.txOn;
  assign timeoutRestart = s_r.timeoutRestart;
  assign timeoutValue = s_r.toValue;

  assign irq = |(statusVec & s_r.intMask & ush_pkg::MASK_VALID);

  // Next-state logic for the bus slave and all flags
  always_comb begin
    logic [ush_pkg::DATA_W-1:0] wMask;
    logic [ush_pkg::DATA_W-1:0] wBits;
    logic [ush_pkg::DATA_W-1:0] cmd;
    logic [ush_pkg::ADDR_W-1:0] wrAddr;
    logic [ush_pkg::ADDR_W-1:0] rdAddr;
    logic doWrite;
    logic doRead;
    logic rhrRead;
    logic csrRead;
    logic thrWrite;
    logic rxOnNow;
    logic rxEnCmd;
    logic rxDisCmd;
    logic txEnCmd;
    logic txDisCmd;
    logic rstStatus;
    wMask = '0;
    wBits = '0;
    cmd = '0;
    wrAddr = '0;
    rdAddr = '0;
    doWrite = 1'b0;
    doRead = 1'b0;
    rhrRead = 1'b0;
    csrRead = 1'b0;
    thrWrite = 1'b0;
    rxOnNow = 1'b0;
    rxEnCmd = 1'b0;
    rxDisCmd = 1'b0;
    txEnCmd = 1'b0;
    txDisCmd = 1'b0;
    rstStatus = 1'b0;
    s_nxt = s_r;

    // Capture write address and data independently
    if (awvalid && !s_r.awHeld && !s_r.bValid) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && !s_r.wHeld && !s_r.bValid) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_r.bValid && bready) begin
      s_nxt.bValid = 1'b0;
    end

    // Byte lanes gate every written bit
    for (int i = 0; i < 4; i++) begin
      wMask[i*8 +: 8] = {8{s_r.wStrb[i]}};
    end
    wBits = s_r.wData & wMask;
    wrAddr = {s_r.awAddr[ush_pkg::ADDR_W-1:2], 2'b00};
    doWrite = s_r.awHeld & s_r.wHeld & ~s_r.bValid;

    // Perform the write and post the response
    if (doWrite) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = ush_pkg::RESP_OKAY;
      case (wrAddr)
        ush_pkg::OFF_TX_HOLD: begin
          thrWrite = 1'b1;
        end
        ush_pkg::OFF_INT_ENABLE: begin
          s_nxt.intMask = s_r.intMask | (wBits & ush_pkg::MASK_VALID);
        end
        ush_pkg::OFF_INT_DISABLE: begin
          s_nxt.intMask = s_r.intMask & ~wBits;
        end
        ush_pkg::OFF_COMMAND: begin
          cmd = wBits;
        end
        ush_pkg::OFF_TIMEOUT: begin
          s_nxt.toValue = (s_r.toValue & ~wMask[ush_pkg::TIMEOUT_W-1:0]) | wBits[ush_pkg::TIMEOUT_W-1:0];
        end
        default: begin
          s_nxt.bResp = ush_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel: data sampled at the address handshake
    rdAddr = {araddr[ush_pkg::ADDR_W-1:2], 2'b00};
    doRead = arvalid & ~s_r.rValid;
    if (s_r.rValid && rready) begin
      s_nxt.rValid = 1'b0;
    end
    if (doRead) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = ush_pkg::RESP_OKAY;
      case (rdAddr)
        ush_pkg::OFF_MASK_VIEW: begin
          s_nxt.rData = s_r.intMask & ush_pkg::MASK_VALID;
        end
        ush_pkg::OFF_STATUS: begin
          s_nxt.rData = statusVec;
          csrRead = 1'b1;
        end
        ush_pkg::OFF_RX_HOLD: begin
          s_nxt.rData = {{(ush_pkg::DATA_W-ush_pkg::CHAR_W){1'b0}}, s_r.receivedCharacter};
          rhrRead = 1'b1;
        end
        ush_pkg::OFF_TIMEOUT: begin
          s_nxt.rData = {{(ush_pkg::DATA_W-ush_pkg::TIMEOUT_W){1'b0}}, s_r.toValue};
        end
        default: begin
          s_nxt.rData = '0;
          s_nxt.rResp = ush_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Command decode; a disable in the same write beats an enable
    rstStatus = cmd[ush_pkg::CMD_RESET_STATUS];
    rxDisCmd = cmd[ush_pkg::CMD_RX_DISABLE];
    rxEnCmd = cmd[ush_pkg::CMD_RX_ENABLE] & ~rxDisCmd;
    txDisCmd = cmd[ush_pkg::CMD_TX_DISABLE];
    txEnCmd = cmd[ush_pkg::CMD_TX_ENABLE] & ~txDisCmd;
    if (rxDisCmd) begin
      s_nxt.rxOn = 1'b0;
    end else if (rxEnCmd) begin
      s_nxt.rxOn = 1'b1;
    end
    if (txDisCmd) begin
      s_nxt.txOn = 1'b0;
    end else if (txEnCmd) begin
      s_nxt.txOn = 1'b1;
    end
    rxOnNow = s_r.rxOn & ~rxDisCmd;

    // Store every arriving character
    if (rxCharValid) begin
      s_nxt.receivedCharacter = rxCharData;
    end

    if (rxDisCmd) begin
      s_nxt.rxPendingOff = s_r.rxPendingOff | s_r.rxCharAvailable | rxCharValid;
    end else if (rxEnCmd) begin
      s_nxt.rxPendingOff = 1'b0;
    end else if (rxCharValid && !s_r.rxOn) begin
      s_nxt.rxPendingOff = 1'b1;
    end

    // receive ready, new character beats the read
    if (rxCharValid && rxOnNow) begin
      s_nxt.rxCharAvailable = 1'b1;
    end else if (rxEnCmd && !s_r.rxOn && (s_r.rxPendingOff || rxCharValid)) begin
      s_nxt.rxCharAvailable = 1'b1;
    end else if (rhrRead || !s_nxt.rxOn) begin
      s_nxt.rxCharAvailable = 1'b0;
    end

    s_nxt.overrunFlag = (s_r.overrunFlag & ~rstStatus) | rxOverrunEvt |
                        (rxCharValid & rxOnNow & s_r.rxCharAvailable & ~rhrRead);
    s_nxt.breakSeenFlag = (s_r.breakSeenFlag & ~rstStatus) | rxBreakEvt;
    s_nxt.framingFlag = (s_r.framingFlag & ~rstStatus) | rxFrameErr;
    s_nxt.parityErrorFlag = (s_r.parityErrorFlag & ~rstStatus) | rxParityErr;
    s_nxt.retryLimitFlag = (s_r.retryLimitFlag & ~cmd[ush_pkg::CMD_RESET_RETRY]) | retryLimitEvt;
    s_nxt.notAcknowledgedFlag = (s_r.notAcknowledgedFlag & ~cmd[ush_pkg::CMD_RESET_NAK]) | nackEvt;

    // timeout flag held low by a zero value
    s_nxt.timeoutRestart = cmd[ush_pkg::CMD_START_TIMEOUT];
    s_nxt.timeoutFlag = (s_nxt.toValue != ush_pkg::TIMEOUT_RESET) &
                        ((s_r.timeoutFlag & ~cmd[ush_pkg::CMD_START_TIMEOUT]) | rxTimeoutEvt);

    // line change latch, cleared by status read
    s_nxt.lineChange = (s_r.lineChange & {ush_pkg::LINE_N{~csrRead}}) | lineChanged;

    // queue character, a new write beats the take
    if (thrWrite) begin
      s_nxt.holdingFull = 1'b1;
      s_nxt.characterToSend = wBits[ush_pkg::CHAR_W-1:0];
    end else if (txCharTake && txCharValid) begin
      s_nxt.holdingFull = 1'b0;
    end

    // break request pending until the engine starts it
    if (cmd[ush_pkg::CMD_START_BREAK] && s_nxt.txOn) begin
      s_nxt.breakPending = 1'b1;
    end else if (breakTaken || !s_nxt.txOn) begin
      s_nxt.breakPending = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.intMask <= ush_pkg::MASK_RESET;
      s_r.toValue <= ush_pkg::TIMEOUT_RESET;
      s_r.receivedCharacter <= ush_pkg::CHAR_RESET;
      s_r.characterToSend <= ush_pkg::CHAR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ush_status_regs

// ---- testbench/ush_engine_model.sv ----
`timescale 1ns/1ps

// Serial engine stand-in: takes held characters and breaks, then shifts for a while
module ush_engine_model #(
  parameter int HOLD = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic txCharValid,
  input wire logic breakRequest,
  input wire logic stall,
  output logic txCharTake,
  output logic txShifterBusy,
  output logic breakTaken
);
  int busyCnt;

  // Accepts work only when idle and not stalled; take pulses last one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busyCnt <= 0;
      txCharTake <= 1'h0;
      breakTaken <= 1'h0;
    end else begin
      txCharTake <= 1'h0;
      breakTaken <= 1'h0;
      if (busyCnt > 0) begin
        busyCnt <= busyCnt - 1;
      end else if (txCharValid && !txCharTake && !stall) begin
        txCharTake <= 1'h1;
        busyCnt <= HOLD;
      end else if (breakRequest && !breakTaken && !stall) begin
        breakTaken <= 1'h1;
        busyCnt <= HOLD;
      end
    end
  end

  // Shifter stays busy while counting down after a character or a break
  assign txShifterBusy = busyCnt != 0;
endmodule : ush_engine_model

// ---- testbench/ush_status_regs_properties.sv ----
`timescale 1ns/1ps

// Port-level checks of the status block
module ush_status_regs_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ush_pkg::ADDR_W-1:0] araddr,
  input wire logic [ush_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txCharValid,
  input wire logic txCharTake,
  input wire logic breakRequest,
  input wire logic breakTaken,
  input wire logic txEnabled,
  input wire logic rxEnabled,
  input wire logic timeoutRestart
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic stRd_r;
  // Remembers whether the read in flight targets the status word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stRd_r <= 1'h0;
    end else if (arvalid && arready) begin
      stRd_r <= araddr == ush_pkg::OFF_STATUS;
    end
  end

  property p_b_stand;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped early");
  property p_r_stand;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped early");
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    $rose(bvalid) |-> !$past(awready) && !$past(wready);
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answered before both taken");
  property p_tx_gate;
    txCharValid |-> txEnabled;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("char offered while transmitter off");
  property p_brk_gate;
    breakRequest |-> txEnabled;
  endproperty
  a_brk_gate: assert property (p_brk_gate) else $error("break pending while transmitter off");
  property p_brk_done;
    breakRequest && breakTaken |=> !breakRequest;
  endproperty
  a_brk_done: assert property (p_brk_done) else $error("break request not cleared");
  property p_tx_free;
    $rose(rvalid) && stRd_r |-> rdata[1] == ($past(txEnabled) && !$past(txCharValid) && !$past(breakRequest));
  endproperty
  a_tx_free: assert property (p_tx_free) else $error("tx free bit wrong");
  property p_rx_off;
    $rose(rvalid) && stRd_r && !$past(rxEnabled) |-> !rdata[0];
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx ready while receiver off");
  property p_tmo_pulse;
    timeoutRestart |=> !timeoutRestart;
  endproperty
  a_tmo_pulse: assert property (p_tmo_pulse) else $error("timeout restart too long");

  c_status_read: cover property (arvalid && arready && araddr == ush_pkg::OFF_STATUS);
  c_tx_take: cover property (txCharValid && txCharTake);
  c_break_done: cover property (breakRequest && breakTaken);
endmodule : ush_status_regs_properties

bind ush_status_regs ush_status_regs_properties u_props (.clock, .rstn, .awready, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .araddr, .rdata, .rvalid, .rready, .txCharValid, .txCharTake, .breakRequest,
  .breakTaken, .txEnabled, .rxEnabled, .timeoutRestart);

// ---- testbench/usart_status_and_holding_bench.sv ----
`timescale 1ns/1ps

module usart_status_and_holding_bench;
  localparam logic [ush_pkg::ADDR_W-1:0] MV = ush_pkg::OFF_MASK_VIEW, ST = ush_pkg::OFF_STATUS,
    RH = ush_pkg::OFF_RX_HOLD, TH = ush_pkg::OFF_TX_HOLD, IE = ush_pkg::OFF_INT_ENABLE,
    ID = ush_pkg::OFF_INT_DISABLE, CM = ush_pkg::OFF_COMMAND, TO = ush_pkg::OFF_TIMEOUT;
  localparam logic [1:0] OK = ush_pkg::RESP_OKAY, SE = ush_pkg::RESP_SLVERR;
  typedef struct packed {logic [7:0] in; logic [31:0] exp;} ush_row_s;
  ush_row_s rows [5] = '{'{8'h00, 32'h0}, '{8'h15, 32'h00100808}, '{8'hAA, 32'h00A01010},
    '{8'hFF, 32'h00F01818}, '{8'h42, 32'h00400010}};
  logic [31:0] sx [4] = '{32'h24E4, 32'h2400, 32'h0400, 32'h0};
  logic clock = 1'h0, rstn = 1'h0, stall = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdV;
  logic [3:0] wstrb = 4'hF, ln = 4'h0, dma = 4'h0;
  logic [7:0] ev = 8'h0;
  logic [8:0] received_character = 9'h0, txCharData;
  logic [15:0] toVal;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, txCharValid, txCharTake, txShifterBusy;
  logic breakRequest, breakTaken, rxEnabled, txEnabled, timeoutRestart, irq;
  wire logic retryLimitEvt, nackEvt, rxTimeoutEvt, rxOverrunEvt, rxBreakEvt, rxFrameErr, rxParityErr, rxCharValid;
  wire logic clearSendLine, carrierLine, setReadyLine, ringLine;
  wire logic rxDmaBufferFull, txDmaBufferEmpty, txDmaTransferEnd, rxDmaTransferEnd;
  int err_count = 0;
  int n_compared = 0;

  // Event, modem and DMA inputs fan out from packed vectors
  assign {retryLimitEvt, nackEvt, rxTimeoutEvt, rxOverrunEvt, rxBreakEvt, rxFrameErr, rxParityErr, rxCharValid} = ev;
  assign {clearSendLine, carrierLine, setReadyLine, ringLine} = ln;
  assign {rxDmaBufferFull, txDmaBufferEmpty, txDmaTransferEnd, rxDmaTransferEnd} = dma;

  ush_status_regs dut (.clock, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxCharValid,
    .rxCharData(received_character), .rxParityErr, .rxFrameErr, .rxBreakEvt, .rxOverrunEvt, .rxTimeoutEvt, .nackEvt,
    .retryLimitEvt, .txCharValid, .txCharData, .txCharTake, .txShifterBusy, .breakRequest, .breakTaken,
    .rxDmaTransferEnd, .txDmaTransferEnd, .txDmaBufferEmpty, .rxDmaBufferFull, .ringLine, .setReadyLine,
    .carrierLine, .clearSendLine, .rxEnabled, .txEnabled, .timeoutRestart, .timeoutValue(toVal), .irq);

  ush_engine_model #(.HOLD(12)) engine (.clock, .rstn, .txCharValid, .breakRequest, .stall, .txCharTake,
    .txShifterBusy, .breakTaken);

  // Free-running clock
  always #12.5 clock = ~clock;

  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One register access; valids drop at their own handshake, ready answers late
  task automatic axi(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    logic tA, tW, done;
    n = 0;
    done = 1'h0;
    @(posedge clock);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    while (!done && n < 40) begin
      @(negedge clock);
      tA = wr ? awvalid && awready : arvalid && arready;
      tW = wvalid && wready;
      done = wr ? bvalid && bready : rvalid && rready;
      rdV = rdata;
      rsp = wr ? bresp : rresp;
      @(posedge clock);
      if (tA) begin
        awvalid <= 1'h0;
        arvalid <= 1'h0;
      end
      if (tW) wvalid <= 1'h0;
      bready <= wr && !done && n >= 2;
      rready <= !wr && !done && n >= 1;
      n++;
    end
    if (!done) begin
      err_count++;
      report_and_stop();
    end
  endtask : axi

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    axi(1'h1, a, d);
    chk({30'h0, rsp}, {30'h0, e});
  endtask : wr

  task automatic chkRd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    axi(1'h0, a, 32'h0);
    chk(rdV & m, e);
  endtask : chkRd

  task automatic pulse(input logic [7:0] m, input logic [8:0] c);
    @(posedge clock);
    ev <= m;
    received_character <= c;
    @(posedge clock);
    ev <= 8'h0;
  endtask : pulse

  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (txShifterBusy !== lvl && n < 60);
    if (n >= 60) begin
      err_count++;
      report_and_stop();
    end
  endtask : waitBusy

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      @(posedge clock);
      {ln, dma} <= rows[i].in;
      chkRd(ST, 32'h00F01818, rows[i].exp);
    end
    chkRd(MV, 32'hFFFFFFFF, 32'h0);
    chkRd(ST, 32'h203, 32'h0);
    chkRd(6'h20, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rsp}, {30'h0, SE});
    chkRd(TH, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rsp}, {30'h0, SE});
    wr(ST, 32'h0, SE);
    axi(1'h0, ST, 32'h0);
    chkRd(ST, 32'h000F0000, 32'h0);
    @(posedge clock);
    ln <= 4'h3;
    chkRd(ST, 32'h000F0000, 32'h00070000);
    chkRd(ST, 32'h000F0000, 32'h0);
    wr(IE, 32'hFFFFFFFF, OK);
    chkRd(MV, 32'hFFFFFFFF, ush_pkg::MASK_VALID);
    wr(ID, 32'hFFFFFFFF, OK);
    chkRd(MV, 32'hFFFFFFFF, 32'h0);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    wr(IE, 32'h10, OK);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    @(posedge clock);
    dma <= 4'h0;
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    pulse(8'h01, 9'h155);
    chkRd(ST, 32'h1, 32'h0);
    wr(CM, 32'h10, OK);
    chkRd(ST, 32'h1, 32'h1);
    chkRd(RH, 32'hFFFFFFFF, 32'h155);
    chkRd(ST, 32'h1, 32'h0);
    pulse(8'h01, 9'h0AA);
    pulse(8'h01, 9'h0AB);
    chkRd(RH, 32'hFFFFFFFF, 32'h0AB);
    pulse(8'hCE, 9'h0);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wr(CM, 32'h1 << (i - 1), OK);
      chkRd(ST, 32'h24E4, sx[i]);
    end
    pulse(8'h20, 9'h0);
    chkRd(ST, 32'h100, 32'h0);
    wr(TO, 32'h5, OK);
    chkRd(TO, 32'hFFFFFFFF, 32'h5);
    chk({16'h0, toVal}, 32'h5);
    wr(CM, 32'h100, OK);
    pulse(8'h20, 9'h0);
    chkRd(ST, 32'h100, 32'h100);
    wr(CM, 32'h40, OK);
    chkRd(ST, 32'h202, 32'h202);
    wr(TH, 32'h1A5, OK);
    chkRd(ST, 32'h202, 32'h0);
    @(negedge clock);
    chk({22'h0, txCharValid, txCharData}, 32'h3A5);
    @(posedge clock);
    stall <= 1'h0;
    waitBusy(1'h1);
    chkRd(ST, 32'h202, 32'h002);
    waitBusy(1'h0);
    chkRd(ST, 32'h202, 32'h202);
    @(posedge clock);
    stall <= 1'h1;
    wr(CM, 32'h8, OK);
    chkRd(ST, 32'h2, 32'h0);
    @(posedge clock);
    stall <= 1'h0;
    waitBusy(1'h1);
    chkRd(ST, 32'h2, 32'h2);
    // Receiver off with a character waiting, then back on
    pulse(8'h01, 9'h033);
    wr(CM, 32'h20, OK);
    chkRd(ST, 32'h1, 32'h0);
    wr(CM, 32'h10, OK);
    chkRd(ST, 32'h1, 32'h1);
    // Both directions off
    wr(CM, 32'hA0, OK);
    chkRd(ST, 32'h203, 32'h0);
    // Reset in mid-run drops the mask
    @(posedge clock);
    rstn <= 1'h0;
    @(posedge clock);
    rstn <= 1'h1;
    chkRd(MV, 32'hFFFFFFFF, 32'h0);
    report_and_stop();
  end
endmodule : usart_status_and_holding_bench
